// [core/emac_status_defines.vh]
`ifndef EMAC_STATUS_DEFINES_VH
`define EMAC_STATUS_DEFINES_VH

// register indices, byte address is four times the index
`define IDX_IRQ_ENABLE 8'h4C
`define IDX_EVENT_STATUS 8'h4D
`define IDX_PHY_READ_DATA_LOW 8'h4E
`define IDX_PHY_READ_DATA_HIGH 8'h4F
`define IDX_MGMT_LINK_STATUS 8'h50
`define IDX_MGMT_COMMAND 8'h40

// event status bit positions
`define BIT_TX_DONE 0
`define BIT_TX_CONTROL_FRAME 1
`define BIT_RX_OVERRUN 2
`define BIT_RX_DONE 3
`define BIT_RX_PAUSE_FRAME 4
`define BIT_RX_CONTROL_FRAME 5
`define BIT_MGMT_DONE 6
`define BIT_TX_FSM_ERROR 7

// event classes for the three interrupt requests
`define CLASS_SYSTEM 8'hC4
`define CLASS_RECEIVE 8'h38
`define CLASS_TRANSMIT 8'h03

// management link status bit positions
`define BIT_MGMT_BUSY 7
`define BIT_LINK_FAIL 6
`define BIT_SCAN_INVALID 5
`define SCAN_ADDR_MSB 4

// management command bit positions
`define BIT_SCAN_ENABLE 0
`define BIT_PHY_READ_CMD 1
`define BIT_PHY_WRITE_CMD 2

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_ADDR 5'h00

`endif

// [core/event_flag_bank.v]
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank (
    input wire sys_clk,       // system clock
    input wire rst,           // asynchronous reset, active high
    input wire [7:0] set_in,  // hardware set requests, one per flag
    input wire [7:0] clear_in, // software one-to-clear requests
    output reg [7:0] flags    // sticky flags
);

    reg [7:0] next_flags;

    always @*
    begin
        next_flags = (flags & ~clear_in) | set_in;
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            flags <= 8'h00;
        end
        else
        begin
            flags <= next_flags;
        end
    end

endmodule
`default_nettype wire

// [core/emac_status_regs.v]
// What this block does
// - after overrun, discard incoming packets until software clears overrun flag.
// - flags never self-clear; writing one to a position clears it unless that flag is set on the same edge.
// - bit 7 sets on transmit state error, held set until transmit reset, then cleared only by software.
// - bit 6 sets when any management read, scan or write completes.
// - bit 5 control frame, bit 4 pause frame, bit 3 receive done.
// - bit 2 sets on receive overrun, a system class event.
// - bit 1 transmit control frame sent, bit 0 transmit done.
// - PHY read data held as sixteen bits, split low and high bytes.
// - busy rises on read or write command, falls on completion.
// - busy stays high throughout scan mode until scanning is disabled.
// - link status bit 6 copies PHY link fail, one means failed.
// - link status bit 5 is one while scan result is invalid.
// - link status bits 4..0 give PHY address of current scan.
// - each event has an enable bit; enabled events raise interrupts.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "emac_status_defines.vh"

module emac_status_regs (
    input wire sys_clk,                // system clock, 200 MHz
    input wire rst,                    // asynchronous reset, active high
    input wire [9:0] avs_address,      // byte address
    input wire avs_read,               // read request
    input wire avs_write,              // write request
    input wire [31:0] avs_writedata,   // write data, low byte used
    input wire [3:0] avs_byteenable,   // byte enables
    output reg [31:0] avs_readdata,    // read data
    output wire avs_waitrequest,       // stall while answer pending
    input wire tx_done_evt,            // transmit packet done pulse
    input wire tx_control_frame_evt,   // transmit control frame sent pulse
    input wire tx_fsm_error_evt,       // transmit state machine error pulse
    input wire tx_path_reset,          // transmit path reset level
    input wire rx_done_evt,            // receive packet done pulse
    input wire rx_pause_frame_evt,     // pause control frame received pulse
    input wire rx_control_frame_evt,   // control frame received pulse
    input wire rx_overrun_evt,         // receive overrun pulse
    output reg rx_discard,             // receiver must ignore packets
    output reg system_irq,             // system class interrupt request
    output reg receive_irq,            // receive class interrupt request
    output reg transmit_irq,           // transmit class interrupt request
    output reg mgmt_read_start,        // start a PHY read, one cycle
    output reg mgmt_write_start,       // start a PHY write, one cycle
    output reg mgmt_scan_enable,       // scan mode level
    input wire mgmt_done,              // management access complete pulse
    input wire mgmt_read_valid,        // mgmt_done carries read data
    input wire [15:0] mgmt_read_data,  // data read from PHY
    input wire mgmt_scan_cycle_start,  // a scan cycle begins, pulse
    input wire [4:0] mgmt_scan_addr,   // PHY address of that scan cycle
    input wire mgmt_link_fail          // link fail bit of last PHY status
);

    // bus answer states
    localparam ST_IDLE = 2'b01;
    localparam ST_ANSWER = 2'b10;

    reg [1:0] bus_state;
    reg [1:0] next_bus_state;
    reg [7:0] irq_enable;
    reg [15:0] phy_read_data;
    reg link_fail_copy;
    reg scan_result_invalid;
    reg [4:0] scanned_phy_addr;
    reg mgmt_op_busy;
    reg phy_read_cmd;
    reg phy_write_cmd;
    reg tx_error_hold;
    wire [7:0] event_status;
    wire [7:0] mgmt_link_status;
    wire [7:0] mgmt_command_reg;
    wire [7:0] flag_set;
    wire [7:0] flag_clear;
    wire bus_req;
    wire wr_fire;
    wire wr_low_lane;
    wire mgmt_busy;
    wire cmd_write;
    wire start_read;
    wire start_write;

    // true when the word address selects the given register index
    function hit;
        input [9:0] addr;
        input [7:0] index;
        begin
            hit = (addr[9:2] == index);
        end
    endfunction

    // readable contents of a register, zero for unmapped addresses
    function [7:0] read_mux;
        input [9:0] addr;
        input [7:0] en;
        input [7:0] evt;
        input [15:0] prd;
        input [7:0] mls;
        input [7:0] cmd;
        begin
            case (addr[9:2])
                `IDX_IRQ_ENABLE: read_mux = en;
                `IDX_EVENT_STATUS: read_mux = evt;
                `IDX_PHY_READ_DATA_LOW: read_mux = prd[7:0];
                `IDX_PHY_READ_DATA_HIGH: read_mux = prd[15:8];
                `IDX_MGMT_LINK_STATUS: read_mux = mls;
                `IDX_MGMT_COMMAND: read_mux = cmd;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // request handshake: every access answers on the second edge
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_state[1];
    assign wr_fire = avs_write & bus_state[1];
    assign wr_low_lane = wr_fire & avs_byteenable[0];

    // bus answer state machine
    always @*
    begin
        case (bus_state)
            ST_IDLE:
            begin
                next_bus_state = bus_req ? ST_ANSWER : ST_IDLE;
            end
            ST_ANSWER:
            begin
                next_bus_state = ST_IDLE;
            end
            default:
            begin
                next_bus_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state <= ST_IDLE;
        end
        else
        begin
            bus_state <= next_bus_state;
        end
    end

    // read data captured one edge before the answer edge
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h00000000;
        end
        else if (avs_read & bus_state[0])
        begin
            avs_readdata <= {24'h000000, read_mux(avs_address, irq_enable,
                event_status, phy_read_data, mgmt_link_status, mgmt_command_reg)};
        end
    end

    // interrupt enable register
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_enable <= `RST_BYTE;
        end
        else if (wr_low_lane & hit(avs_address, `IDX_IRQ_ENABLE))
        begin
            irq_enable <= avs_writedata[7:0];
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_error_hold <= 1'b0;
        end
        else if (tx_path_reset)
        begin
            tx_error_hold <= 1'b0;
        end
        else if (tx_fsm_error_evt)
        begin
            tx_error_hold <= 1'b1;
        end
    end

    assign flag_set[`BIT_TX_FSM_ERROR] = tx_error_hold | tx_fsm_error_evt;
    assign flag_set[`BIT_MGMT_DONE] = mgmt_done;
    assign flag_set[`BIT_RX_CONTROL_FRAME] = rx_control_frame_evt & ~rx_discard;
    assign flag_set[`BIT_RX_PAUSE_FRAME] = rx_pause_frame_evt & ~rx_discard;
    assign flag_set[`BIT_RX_DONE] = rx_done_evt & ~rx_discard;
    assign flag_set[`BIT_RX_OVERRUN] = rx_overrun_evt;
    assign flag_set[`BIT_TX_CONTROL_FRAME] = tx_control_frame_evt;
    assign flag_set[`BIT_TX_DONE] = tx_done_evt;

    assign flag_clear = (wr_low_lane & hit(avs_address, `IDX_EVENT_STATUS)) ?
        avs_writedata[7:0] : 8'h00;

    // sticky event flags
    event_flag_bank flag_bank (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_in(flag_set),
        .clear_in(flag_clear),
        .flags(event_status)
    );

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_discard <= 1'b0;
        end
        else
        begin
            rx_discard <= event_status[`BIT_RX_OVERRUN] | rx_overrun_evt;
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            system_irq <= 1'b0;
            receive_irq <= 1'b0;
            transmit_irq <= 1'b0;
        end
        else
        begin
            system_irq <= |(event_status & irq_enable & `CLASS_SYSTEM);
            receive_irq <= |(event_status & irq_enable & `CLASS_RECEIVE);
            transmit_irq <= |(event_status & irq_enable & `CLASS_TRANSMIT);
        end
    end

    // management command decode; a read or write command while busy is dropped, scan enable always loads, read beats write
    assign cmd_write = wr_low_lane & hit(avs_address, `IDX_MGMT_COMMAND);
    assign start_read = cmd_write & avs_writedata[`BIT_PHY_READ_CMD] & ~mgmt_busy;
    assign start_write = cmd_write & avs_writedata[`BIT_PHY_WRITE_CMD] & ~mgmt_busy
        & ~avs_writedata[`BIT_PHY_READ_CMD];

    // command bits, start pulses and scan enable
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phy_read_cmd <= 1'b0;
            phy_write_cmd <= 1'b0;
            mgmt_scan_enable <= 1'b0;
            mgmt_read_start <= 1'b0;
            mgmt_write_start <= 1'b0;
        end
        else
        begin
            mgmt_read_start <= start_read;
            mgmt_write_start <= start_write;
            if (cmd_write)
            begin
                mgmt_scan_enable <= avs_writedata[`BIT_SCAN_ENABLE];
            end
            if (start_read)
            begin
                phy_read_cmd <= 1'b1;
            end
            else if (mgmt_done)
            begin
                phy_read_cmd <= 1'b0;
            end
            if (start_write)
            begin
                phy_write_cmd <= 1'b1;
            end
            else if (mgmt_done)
            begin
                phy_write_cmd <= 1'b0;
            end
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mgmt_op_busy <= 1'b0;
        end
        else if (start_read | start_write)
        begin
            mgmt_op_busy <= 1'b1;
        end
        else if (mgmt_done)
        begin
            mgmt_op_busy <= 1'b0;
        end
    end

    assign mgmt_busy = mgmt_op_busy | mgmt_scan_enable;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phy_read_data <= `RST_WORD;
        end
        else if (mgmt_done & mgmt_read_valid)
        begin
            phy_read_data <= mgmt_read_data;
        end
    end

    // scan progress and link copy
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            link_fail_copy <= 1'b0;
            scan_result_invalid <= 1'b0;
            scanned_phy_addr <= `RST_ADDR;
        end
        else
        begin
            link_fail_copy <= mgmt_link_fail;
            if (mgmt_done & mgmt_read_valid)
            begin
                scan_result_invalid <= 1'b0;
            end
            else if (mgmt_scan_cycle_start)
            begin
                scan_result_invalid <= 1'b1;
            end
            if (mgmt_scan_cycle_start)
            begin
                scanned_phy_addr <= mgmt_scan_addr;
            end
        end
    end

    // status and command read views
    assign mgmt_link_status = {mgmt_busy, link_fail_copy, scan_result_invalid,
        scanned_phy_addr};
    assign mgmt_command_reg = {5'h00, phy_write_cmd, phy_read_cmd, mgmt_scan_enable};

endmodule
`default_nettype wire

// [sim/phy_mgmt_model.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_model #(
    parameter int LINK_BIT = 2
) (
    input wire logic sys_clk,            // clock
    input wire logic rst,                // reset
    input wire logic read_start,         // read request
    input wire logic write_start,        // write request
    input wire logic scan_enable,        // scan mode
    input wire logic [3:0] lat,          // answer delay
    input wire logic [15:0] word,        // status word held by the phy
    output logic done,                   // access complete
    output logic read_valid,             // done carries data
    output logic scan_start,             // scan cycle begins
    output logic link_fail,              // link down
    output logic [4:0] scan_addr,        // scanned address
    output logic [15:0] read_data        // returned word
);
    int cnt;
    logic wr_op;
    // one access at a time; released data toggles so stale values never match
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {cnt, done, read_valid, scan_start, link_fail, scan_addr, read_data, wr_op} <= '0;
        end
        else
        begin
            done <= 1'b0;
            read_valid <= 1'b0;
            scan_start <= 1'b0;
            read_data <= ~read_data;
            if (cnt == 0 && (read_start || write_start))
            begin
                cnt <= lat + 1;
                wr_op <= write_start && !read_start;
            end
            else if (cnt == 0 && scan_enable)
            begin
                cnt <= lat + 1;
                wr_op <= 1'b0;
                scan_start <= 1'b1;
                scan_addr <= scan_addr + 5'h01;
            end
            else if (cnt == 1)
            begin
                cnt <= 0;
                done <= 1'b1;
                read_valid <= !wr_op;
                if (!wr_op)
                begin
                    read_data <= word ^ {11'h000, scan_addr};
                    link_fail <= ~word[LINK_BIT];
                end
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// [sim/emac_status_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module emac_status_checker (
    input wire sys_clk,              // clock
    input wire rst,                  // reset
    input wire [9:0] avs_address,    // address
    input wire avs_read,             // read
    input wire avs_write,            // write
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // enables
    input wire [31:0] avs_readdata,  // read data
    input wire avs_waitrequest,      // stall
    input wire rx_overrun_evt,       // overrun
    input wire rx_discard,           // discard
    input wire mgmt_read_start,      // read start
    input wire mgmt_write_start,     // write start
    input wire mgmt_scan_enable      // scan
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // accepted command and overrun-clear writes
    wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire cmd_wr = acc && avs_address == 10'h100;
    wire clr_ovr = acc && avs_address == 10'h134 && avs_writedata[2];
    AST_OVR_DISCARD: assert property (rx_overrun_evt |=> rx_discard)
        else $error("discard missing after overrun");
    AST_DISCARD_HOLD: assert property (rx_discard && !clr_ovr && !$past(clr_ovr) |=> rx_discard)
        else $error("discard dropped without clear");
    AST_DISCARD_FALL: assert property ($fell(rx_discard) |-> $past(clr_ovr) || $past(clr_ovr, 2))
        else $error("discard fell without clear");
    AST_READ_START: assert property ($rose(mgmt_read_start) |-> $past(cmd_wr && avs_writedata[1]))
        else $error("read start without command");
    AST_WRITE_START: assert property ($rose(mgmt_write_start) |-> $past(cmd_wr && avs_writedata[2]))
        else $error("write start without command");
    AST_START_PULSE: assert property (mgmt_read_start || mgmt_write_start |=> !(mgmt_read_start || mgmt_write_start))
        else $error("start longer than one cycle");
    AST_SCAN_FOLLOW: assert property (cmd_wr |=> mgmt_scan_enable == $past(avs_writedata[0]))
        else $error("scan enable not loaded");
    AST_SCAN_STEADY: assert property (!$stable(mgmt_scan_enable) |-> $past(cmd_wr))
        else $error("scan enable changed alone");
    AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    cover property (rx_overrun_evt ##1 rx_discard);
    cover property ($rose(mgmt_read_start));
    cover property ($rose(mgmt_scan_enable));
endmodule
bind emac_status_regs emac_status_checker chk_u (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .rx_overrun_evt, .rx_discard, .mgmt_read_start, .mgmt_write_start, .mgmt_scan_enable);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, rx_discard, system_irq, receive_irq, transmit_irq;
    logic mgmt_read_start, mgmt_write_start, mgmt_scan_enable;
    logic mgmt_done, mgmt_read_valid, mgmt_scan_cycle_start, mgmt_link_fail;
    logic [15:0] mgmt_read_data;
    logic [4:0] mgmt_scan_addr;
    logic [7:0] ev = 8'h00;
    logic tx_path_reset = 1'b0;
    logic [3:0] lat = 4'h0;
    logic [15:0] word = 16'h0000;
    logic [7:0] q;
    logic [9:0] regs [5] = '{10'h134, 10'h138, 10'h13C, 10'h140, 10'h3FC};
    int error_cnt = 0, tests_run = 0, cyc = 0, nscan = 0, exp_st = 0, exp_en = 0, i, n;
    bit hold = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    emac_status_regs dut_u (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .tx_done_evt(ev[0]), .tx_control_frame_evt(ev[1]), .tx_fsm_error_evt(ev[7]),
        .tx_path_reset, .rx_done_evt(ev[3]), .rx_pause_frame_evt(ev[4]),
        .rx_control_frame_evt(ev[5]), .rx_overrun_evt(ev[2]), .rx_discard, .system_irq,
        .receive_irq, .transmit_irq, .mgmt_read_start, .mgmt_write_start, .mgmt_scan_enable,
        .mgmt_done, .mgmt_read_valid, .mgmt_read_data, .mgmt_scan_cycle_start,
        .mgmt_scan_addr, .mgmt_link_fail);
    phy_mgmt_model phy_u (.sys_clk, .rst, .read_start(mgmt_read_start),
        .write_start(mgmt_write_start), .scan_enable(mgmt_scan_enable), .lat, .word,
        .done(mgmt_done), .read_valid(mgmt_read_valid), .scan_start(mgmt_scan_cycle_start),
        .link_fail(mgmt_link_fail), .scan_addr(mgmt_scan_addr), .read_data(mgmt_read_data));
    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] be);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [9:0] a, input int e);
        bus(1'b0, a, 8'h00, 4'h1);
        `CHK(q, e[7:0])
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    // one-cycle event pulses, model drops receive events while discarding
    task automatic pulse(input logic [7:0] v);
        ev <= v;
        @(posedge sys_clk);
        ev <= 8'h00;
        @(posedge sys_clk);
        if (v[7]) hold = 1;
        exp_st |= v & (exp_st[2] ? 8'hC7 : 8'hFF);
    endtask
    task automatic clr(input logic [7:0] c);
        wr(10'h134, c);
        exp_st &= ~c;
        if (hold) exp_st |= 8'h80;
    endtask
    task automatic irq_chk;
        `CHK(system_irq, |(exp_st & exp_en & 8'hC4))
        `CHK(receive_irq, |(exp_st & exp_en & 8'h38))
        `CHK(transmit_irq, |(exp_st & exp_en & 8'h03))
    endtask
    task automatic rst_chk;
        foreach (regs[k]) rd(regs[k], 0);
        rd(10'h130, 0);
    endtask
    // poll the done flag, not busy
    task automatic wait_done;
        n = 0;
        do begin bus(1'b0, 10'h134, 8'h00, 4'h1); n++; end while (q[6] !== 1'b1 && n < 60);
        `CHK(q[6], 1'b1)
        exp_st |= 8'h40;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            report_and_stop;
        end
    end
    always @(posedge sys_clk) if (mgmt_scan_cycle_start === 1'b1) nscan++;
    initial
    begin
        void'($urandom(7));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rst_chk;
        $display("reset test done");
        pulse(8'hBB);
        rd(10'h134, exp_st);
        `CHK(q[1:0], 2'b11)
        for (i = 0; i < 24; i++)
        begin
            exp_en = $urandom & 8'hFF;
            wr(10'h130, exp_en[7:0]);
            rd(10'h130, exp_en);
            irq_chk;
            pulse($urandom & 8'hBB);
            clr($urandom & 8'hFF);
            rd(10'h134, exp_st);
        end
        // clear and set on the same edge
        pulse(8'h01);
        fork
            clr(8'h01);
            begin
                @(posedge sys_clk);
                ev <= 8'h01;
                @(posedge sys_clk);
                ev <= 8'h00;
            end
        join
        exp_st |= 8'h01;
        rd(10'h134, exp_st);
        clr(8'h00);
        bus(1'b1, 10'h134, 8'hFF, 4'h0);
        rd(10'h134, exp_st);
        clr(8'h80);
        rd(10'h134, exp_st);
        tx_path_reset <= 1'b1;
        @(posedge sys_clk);
        tx_path_reset <= 1'b0;
        hold = 0;
        clr(8'hFF);
        rd(10'h134, 0);
        $display("event test done");
        exp_en = 8'h04;
        wr(10'h130, 8'h04);
        pulse(8'h04);
        pulse(8'h38);
        rd(10'h134, exp_st);
        `CHK(rx_discard, 1'b1)
        irq_chk;
        clr(8'h04);
        pulse(8'h08);
        rd(10'h134, exp_st);
        `CHK(rx_discard, 1'b0)
        clr(8'hFF);
        $display("overrun test done");
        word <= 16'($urandom);
        lat <= 4'hC;
        wr(10'h100, 8'h02);
        rd(10'h100, 8'h02);
        rd(10'h140, 8'h80);
        wait_done;
        rd(10'h138, word[7:0]);
        rd(10'h13C, word[15:8]);
        rd(10'h140, {1'b0, ~word[2], 6'h00});
        rd(10'h134, exp_st);
        clr(8'h40);
        lat <= 4'h0;
        wr(10'h100, 8'h04);
        wait_done;
        rd(10'h13C, word[15:8]);
        rd(10'h140, {1'b0, ~word[2], 6'h00});
        clr(8'h40);
        lat <= 4'h3;
        wr(10'h100, 8'h01);
        repeat (6)
        begin
            bus(1'b0, 10'h140, 8'h00, 4'h1);
            `CHK(q[7], 1'b1)
        end
        wr(10'h100, 8'h00);
        repeat (20) @(posedge sys_clk);
        rd(10'h140, {1'b0, ~word[2], 1'b0, nscan[4:0]});
        rd(10'h138, word[7:0] ^ {3'b000, nscan[4:0]});
        exp_st |= 8'h40;
        rd(10'h134, exp_st);
        $display("management test done");
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rst_chk;
        $display("second reset test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
